// *** lbr_ctrl.sv ***
// Local-bus block RAM controller: port sharing, byte lanes, optional ECC.
`timescale 1ns/10ps
module lbr_ctrl #(
  parameter int NUM_PORTS = lbr_pkg::DEF_PORTS,
  parameter int MEM_BYTES = lbr_pkg::DEF_MEM_BYTES,
  parameter bit ECC_ON    = 1'b1
) (
  input  wire logic                                     clk,
  input  wire logic                                     rstn,
  input  wire logic                                     bus_reset_in,
  input  wire logic [NUM_PORTS-1:0]                     bus_addr_valid,
  input  wire logic [NUM_PORTS-1:0]                     bus_read_strobe,
  input  wire logic [NUM_PORTS-1:0]                     bus_write_strobe,
  input  wire logic [NUM_PORTS-1:0][lbr_pkg::DATA_W-1:0] bus_addr,
  input  wire logic [NUM_PORTS-1:0][lbr_pkg::DATA_W-1:0] bus_wdata,
  input  wire logic [NUM_PORTS-1:0][lbr_pkg::LANES-1:0]  bus_lane_enables,
  output logic      [NUM_PORTS-1:0][lbr_pkg::DATA_W-1:0] port_rdata,
  output logic      [NUM_PORTS-1:0]                     port_ready,
  output logic      [NUM_PORTS-1:0]                     port_wait,
  output logic      [NUM_PORTS-1:0]                     port_correctable_err,
  output logic      [NUM_PORTS-1:0]                     port_uncorrectable_err,
  output logic                                          ecc_correctable_pulse,
  output logic                                          ecc_uncorrectable_pulse,
  output logic                                          mem_en,
  output logic      [lbr_pkg::MEM_LANES-1:0]             mem_we,
  output logic      [$clog2(MEM_BYTES)-3:0]              mem_addr,
  output logic      [lbr_pkg::MEM_W-1:0]                 mem_wdata,
  input  wire logic [lbr_pkg::MEM_W-1:0]                 mem_rdata
);

  // ----------------------------------------------------------------------
  // Sizes.
  // ----------------------------------------------------------------------
  localparam int AW = $clog2(MEM_BYTES);
  localparam int WA = AW - lbr_pkg::WORD_SHIFT;
  localparam int PW = (NUM_PORTS > 1) ? $clog2(NUM_PORTS) : 1;

  typedef struct packed {
    lbr_pkg::lbr_phase_t                      phase;
    logic [PW-1:0]                            owner;
    logic [WA-1:0]                            rmw_addr;
    logic [lbr_pkg::DATA_W-1:0]               rmw_data;
    logic [lbr_pkg::LANES-1:0]                rmw_be;
    logic                                     rd_valid;
    logic [PW-1:0]                            rd_port;
    logic [NUM_PORTS-1:0]                     pend;
    logic [NUM_PORTS-1:0]                     pend_wr;
    logic [NUM_PORTS-1:0][AW-1:0]             pend_addr;
    logic [NUM_PORTS-1:0][lbr_pkg::DATA_W-1:0] pend_data;
    logic [NUM_PORTS-1:0][lbr_pkg::LANES-1:0]  pend_be;
    logic [NUM_PORTS-1:0]                     ready;
    logic [NUM_PORTS-1:0]                     waiting;
  } lbr_regs_t;

  lbr_regs_t s;
  lbr_regs_t next_s;

  // ----------------------------------------------------------------------
  // Hamming code over 38 positions plus an overall parity bit.
  // ----------------------------------------------------------------------
  // Data bits fill every code position that is not a power of two, so the
  // syndrome of a single flipped data bit equals its position.
  function automatic logic [lbr_pkg::SYN_W-1:0] lbr_syn(
    input logic [lbr_pkg::DATA_W-1:0] d
  );
    logic [lbr_pkg::SYN_W-1:0] c;
    int                        i;
    c = '0;
    i = 0;
    for (int p = 3; p <= lbr_pkg::CODE_LAST; p++) begin
      if ((p & (p - 1)) != 0) begin
        if (d[i]) begin
          c = c ^ p[lbr_pkg::SYN_W-1:0];
        end
        i = i + 1;
      end
    end
    return c;
  endfunction : lbr_syn

  function automatic logic [lbr_pkg::LANE_W-1:0] lbr_chk(
    input logic [lbr_pkg::DATA_W-1:0] d
  );
    logic [lbr_pkg::SYN_W-1:0] c;
    c = lbr_syn(d);
    return {1'b0, (^d) ^ (^c), c};
  endfunction : lbr_chk

  function automatic logic [lbr_pkg::DATA_W-1:0] lbr_fix(
    input logic [lbr_pkg::DATA_W-1:0] d,
    input logic [lbr_pkg::SYN_W-1:0]  syn
  );
    logic [lbr_pkg::DATA_W-1:0] r;
    int                         i;
    r = d;
    i = 0;
    for (int p = 3; p <= lbr_pkg::CODE_LAST; p++) begin
      if ((p & (p - 1)) != 0) begin
        if (p[lbr_pkg::SYN_W-1:0] == syn) begin
          r[i] = ~r[i];
        end
        i = i + 1;
      end
    end
    return r;
  endfunction : lbr_fix

  // ----------------------------------------------------------------------
  // Byte lane merge.
  // ----------------------------------------------------------------------
  // Enabled lanes take the new byte and the others keep the stored one, so a
  // partial write never disturbs its neighbours in the same word.
  function automatic logic [lbr_pkg::DATA_W-1:0] lbr_merge(
    input logic [lbr_pkg::DATA_W-1:0] old_word,
    input logic [lbr_pkg::DATA_W-1:0] new_word,
    input logic [lbr_pkg::LANES-1:0]  lane_en
  );
    logic [lbr_pkg::DATA_W-1:0] r;
    r = old_word;
    for (int l = 0; l < lbr_pkg::LANES; l++) begin
      if (lane_en[l]) begin
        r[l*lbr_pkg::LANE_W +: lbr_pkg::LANE_W] =
          new_word[l*lbr_pkg::LANE_W +: lbr_pkg::LANE_W];
      end
    end
    return r;
  endfunction : lbr_merge

  // ----------------------------------------------------------------------
  // Read path decode.
  // ----------------------------------------------------------------------
  logic [lbr_pkg::DATA_W-1:0] raw_data;
  logic [lbr_pkg::DATA_W-1:0] cor_data;
  logic [lbr_pkg::SYN_W-1:0]  syn;
  logic                       par_bad;
  logic                       err_single;
  logic                       err_double;

  always_comb begin
    raw_data   = mem_rdata[lbr_pkg::DATA_W-1:0];
    syn        = lbr_syn(raw_data) ^ mem_rdata[lbr_pkg::DATA_W +: lbr_pkg::SYN_W];
    par_bad    = (^raw_data) ^ (^mem_rdata[lbr_pkg::DATA_W +: lbr_pkg::CHK_W]);
    err_single = ECC_ON && par_bad;
    err_double = ECC_ON && !par_bad && (syn != '0);
    // Correction is pure logic on the returning word, so it adds no cycle.
    cor_data   = err_single ? lbr_fix(raw_data, syn) : raw_data;
  end

  // ----------------------------------------------------------------------
  // Arbitration, memory drive and next state.
  // ----------------------------------------------------------------------
  logic [NUM_PORTS-1:0] req;
  logic                 gnt_any;
  logic [PW-1:0]        gnt;
  logic                 g_wr;
  logic [AW-1:0]        g_addr;
  logic [lbr_pkg::DATA_W-1:0] g_data;
  logic [lbr_pkg::LANES-1:0]  g_be;

  always_comb begin
    next_s    = s;
    next_s.ready    = '0;
    next_s.rd_valid = 1'b0;
    mem_en    = 1'b0;
    mem_we    = lbr_pkg::WE_NONE;
    mem_addr  = '0;
    mem_wdata = '0;
    gnt_any   = 1'b0;
    gnt       = '0;
    req       = s.pend | bus_addr_valid;

    // Lowest numbered requester wins; a held port competes on equal terms.
    for (int p = NUM_PORTS - 1; p >= 0; p--) begin
      if (req[p]) begin
        gnt_any = 1'b1;
        gnt     = PW'(p);
      end
    end
    // A read is any strobe without the write strobe, so the read strobe is not decoded.
    g_wr   = s.pend[gnt] ? s.pend_wr[gnt]   : bus_write_strobe[gnt];
    g_addr = s.pend[gnt] ? s.pend_addr[gnt] : bus_addr[gnt][AW-1:0];
    g_data = s.pend[gnt] ? s.pend_data[gnt] : bus_wdata[gnt];
    g_be   = s.pend[gnt] ? s.pend_be[gnt]   : bus_lane_enables[gnt];

    // Hold every new request that is not served in this cycle, unless its port already holds one.
    for (int p = 0; p < NUM_PORTS; p++) begin
      if (bus_addr_valid[p] && !s.pend[p]) begin
        next_s.pend[p]      = 1'b1;
        next_s.pend_wr[p]   = bus_write_strobe[p];
        next_s.pend_addr[p] = bus_addr[p][AW-1:0];
        next_s.pend_data[p] = bus_wdata[p];
        next_s.pend_be[p]   = bus_lane_enables[p];
      end
    end

    case (s.phase)
      lbr_pkg::LBR_IDLE: begin
        if (gnt_any) begin
          next_s.pend[gnt] = 1'b0;
          mem_en   = 1'b1;
          mem_addr = g_addr[AW-1:lbr_pkg::WORD_SHIFT];
          if (!g_wr) begin
            next_s.rd_valid  = 1'b1;
            next_s.rd_port   = gnt;
            next_s.ready[gnt] = 1'b1;
          end else if (ECC_ON && (g_be != lbr_pkg::FULL_WORD_BE)) begin
            // Check bits cover the whole word, so fetch it first.
            next_s.phase    = lbr_pkg::LBR_MERGE;
            next_s.owner    = gnt;
            next_s.rmw_addr = g_addr[AW-1:lbr_pkg::WORD_SHIFT];
            next_s.rmw_data = g_data;
            next_s.rmw_be   = g_be;
            next_s.rd_valid = 1'b1;
            next_s.rd_port  = gnt;
          end else begin
            mem_we    = ECC_ON ? lbr_pkg::WE_ALL : {1'b0, g_be};
            mem_wdata = {ECC_ON ? lbr_chk(g_data) : lbr_pkg::CHK_NONE, g_data};
            next_s.ready[gnt] = 1'b1;
          end
        end
      end
      lbr_pkg::LBR_MERGE: begin
        next_s.rmw_data = lbr_merge(cor_data, s.rmw_data, s.rmw_be);
        next_s.phase = lbr_pkg::LBR_WRITE;
      end
      lbr_pkg::LBR_WRITE: begin
        mem_en    = 1'b1;
        mem_we    = lbr_pkg::WE_ALL;
        mem_addr  = s.rmw_addr;
        mem_wdata = {lbr_chk(s.rmw_data), s.rmw_data};
        next_s.ready[s.owner] = 1'b1;
        next_s.phase = lbr_pkg::LBR_IDLE;
      end
      default: begin
        next_s.phase = lbr_pkg::LBR_IDLE;
      end
    endcase

    // Wait covers held requests and the owner of a merge in progress.
    next_s.waiting = next_s.pend;
    if (next_s.phase != lbr_pkg::LBR_IDLE) begin
      next_s.waiting[next_s.owner] = 1'b1;
    end

    // A bus reset drops any strobe of its cycle, so the memory is left untouched.
    if (bus_reset_in) begin
      next_s    = '0;
      mem_en    = 1'b0;
      mem_we    = lbr_pkg::WE_NONE;
      mem_addr  = '0;
      mem_wdata = '0;
    end
  end

  // ----------------------------------------------------------------------
  // Error reporting and read data fan-out.
  // ----------------------------------------------------------------------
  // These follow the returning memory word without a register; a register
  // here would cost the single-cycle read latency.
  always_comb begin
    ecc_correctable_pulse   = s.rd_valid && err_single;
    ecc_uncorrectable_pulse = s.rd_valid && err_double;
    for (int p = 0; p < NUM_PORTS; p++) begin
      port_rdata[p]             = cor_data;
      port_correctable_err[p]   = ecc_correctable_pulse && (s.rd_port == PW'(p));
      port_uncorrectable_err[p] = ecc_uncorrectable_pulse && (s.rd_port == PW'(p));
    end
    port_ready = s.ready;
    port_wait  = s.waiting;
  end

  // ----------------------------------------------------------------------
  // State register.
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

endmodule : lbr_ctrl

// *** lbr_pkg.sv ***
// Shared constants and types of the local-bus block RAM controller.
package lbr_pkg;

  // ----------------------------------------------------------------------
  // Widths of the data path and the memory word.
  // ----------------------------------------------------------------------
  localparam int DATA_W    = 32;
  localparam int LANES     = 4;
  localparam int LANE_W    = 8;
  localparam int CHK_W     = 7;
  localparam int MEM_W     = 40;
  localparam int MEM_LANES = 5;
  localparam int SYN_W     = 6;
  localparam int CODE_LAST = 38;

  // ----------------------------------------------------------------------
  // Build defaults.
  // ----------------------------------------------------------------------
  localparam int DEF_PORTS     = 2;
  localparam int DEF_MEM_BYTES = 8192;
  localparam int MIN_MEM_BYTES = 2048;
  localparam int MAX_MEM_BYTES = 131072;
  localparam int WORD_SHIFT    = 2;

  // ----------------------------------------------------------------------
  // Reset values and lane patterns.
  // ----------------------------------------------------------------------
  localparam logic [LANES-1:0]     FULL_WORD_BE = 4'hF;
  localparam logic [MEM_LANES-1:0] WE_NONE      = 5'h00;
  localparam logic [MEM_LANES-1:0] WE_ALL       = 5'h1F;
  localparam logic [LANE_W-1:0]    CHK_NONE     = 8'h00;

  // ----------------------------------------------------------------------
  // Memory port phase.
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    LBR_IDLE  = 2'b00,
    LBR_MERGE = 2'b01,
    LBR_WRITE = 2'b10
  } lbr_phase_t;

endpackage : lbr_pkg

// *** lbr_ctrl_checker.sv ***
// Concurrent checks on the controller's bus and memory ports.
`timescale 1ns/10ps
module lbr_ctrl_checker #(parameter int NUM_PORTS = 2, parameter bit ECC_ON = 1'b1) (
  input wire logic                                      clk,
  input wire logic                                      rstn,
  input wire logic                                      bus_reset_in,
  input wire logic [NUM_PORTS-1:0]                      bus_addr_valid,
  input wire logic [NUM_PORTS-1:0]                      bus_write_strobe,
  input wire logic [NUM_PORTS-1:0][lbr_pkg::LANES-1:0]  bus_lane_enables,
  input wire logic [NUM_PORTS-1:0]                      port_ready,
  input wire logic [NUM_PORTS-1:0]                      port_wait,
  input wire logic [NUM_PORTS-1:0]                      port_correctable_err,
  input wire logic [NUM_PORTS-1:0]                      port_uncorrectable_err,
  input wire logic                                      ecc_correctable_pulse,
  input wire logic                                      ecc_uncorrectable_pulse,
  input wire logic                                      mem_en,
  input wire logic [lbr_pkg::MEM_LANES-1:0]             mem_we
);
  logic prev_req;
  logic quiet;
  logic prev_rd;
  // An idle cycle with no wait anywhere proves the memory free; cheaper than a phase copy.
  assign quiet = !prev_req && !(|port_wait);
  always_ff @(posedge clk) prev_req <= (|bus_addr_valid) || !rstn;
  // A fresh read in the previous cycle is what entitles this cycle to an error pulse.
  always_ff @(posedge clk) prev_rd <= mem_en && (mem_we == lbr_pkg::WE_NONE);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn || bus_reset_in);
  a_read_latency:
    assert property (bus_addr_valid[0] && !bus_write_strobe[0] && quiet |-> mem_en
      && mem_we == lbr_pkg::WE_NONE ##1 port_ready[0] && !port_wait[0])
    else $error("read not answered in the next cycle");
  a_full_write:
    assert property (bus_addr_valid[0] && bus_write_strobe[0] && quiet
      && bus_lane_enables[0] == lbr_pkg::FULL_WORD_BE
      |-> mem_en && mem_we == (ECC_ON ? lbr_pkg::WE_ALL : {1'b0, bus_lane_enables[0]})
      ##1 port_ready[0])
    else $error("full word write not done at once");
  a_sub_word_rmw:
    assert property (ECC_ON && bus_addr_valid[0] && bus_write_strobe[0] && quiet
      && bus_lane_enables[0] != lbr_pkg::FULL_WORD_BE |-> mem_we == lbr_pkg::WE_NONE
      ##1 port_wait[0] && !port_ready[0] ##1 port_wait[0] && mem_we == lbr_pkg::WE_ALL
      ##1 port_ready[0] && !port_wait[0])
    else $error("sub-word write not read, merged and rewritten");
  a_lowest_first:
    assert property (bus_addr_valid[1:0] == 2'b11 && bus_write_strobe[1:0] == 2'b00 && quiet
      |=> port_ready[0] && port_wait[1] ##1 ($past(bus_addr_valid[0]) || port_ready[1]))
    else $error("contending ports not served in order");
  a_ready_once:
    assert property (port_ready[0] && !bus_addr_valid[0] |=> !port_ready[0])
    else $error("ready longer than one cycle");
  a_wait_excl:
    assert property ((port_ready & port_wait) == '0)
    else $error("ready and wait together");
  a_err_sum:
    assert property ({ecc_uncorrectable_pulse, ecc_correctable_pulse}
      == {|port_uncorrectable_err, |port_correctable_err})
    else $error("error pulse differs from port flags");
  a_err_slot:
    assert property (((port_correctable_err | port_uncorrectable_err)
      & ~(port_ready | port_wait)) == '0)
    else $error("error flag outside its port's access");
  a_pulse_fresh:
    assert property ((ecc_correctable_pulse || ecc_uncorrectable_pulse) |-> prev_rd)
    else $error("error pulse without a fresh memory read");
  c_sub_word: cover property (bus_addr_valid[0] && bus_write_strobe[0] && quiet
    && bus_lane_enables[0] != lbr_pkg::FULL_WORD_BE);
  c_contend: cover property (bus_addr_valid[1:0] == 2'b11 && quiet);
  c_corrected: cover property (ecc_correctable_pulse);
endmodule : lbr_ctrl_checker
bind lbr_ctrl lbr_ctrl_checker #(.NUM_PORTS(NUM_PORTS), .ECC_ON(ECC_ON)) u_lbr_ctrl_checker (
  .clk, .rstn, .bus_reset_in, .bus_addr_valid, .bus_write_strobe, .bus_lane_enables,
  .port_ready, .port_wait, .port_correctable_err, .port_uncorrectable_err,
  .ecc_correctable_pulse, .ecc_uncorrectable_pulse, .mem_en, .mem_we);

// *** lbr_ram_model.sv ***
// Synchronous block RAM model on the controller's memory port.
`timescale 1ns/10ps
module lbr_ram_model #(parameter int AW = 9) (
  input wire logic                          clk,
  input wire logic                          mem_en,
  input wire logic [lbr_pkg::MEM_LANES-1:0] mem_we,
  input wire logic [AW-1:0]                 mem_addr,
  input wire logic [lbr_pkg::MEM_W-1:0]     mem_wdata,
  input wire logic [lbr_pkg::MEM_W-1:0]     flip,
  output logic     [lbr_pkg::MEM_W-1:0]     mem_rdata
);
  logic [lbr_pkg::MEM_W-1:0] ram [2**AW];
  logic [lbr_pkg::MEM_W-1:0] q;
  // Read-first, and the output holds while disabled as a real RAM does.
  always_ff @(posedge clk) begin
    if (mem_en) begin
      q <= ram[mem_addr];
      for (int l = 0; l < lbr_pkg::MEM_LANES; l++) begin
        if (mem_we[l]) ram[mem_addr][l*8 +: 8] <= mem_wdata[l*8 +: 8];
      end
    end
  end
  // Flipped bits stand for upsets in the stored word.
  assign mem_rdata = q ^ flip;
endmodule : lbr_ram_model

// *** lbr_ctrl_tb.sv ***
// Self-checking bench of the block RAM controller.
`timescale 1ns/10ps
module lbr_ctrl_tb;
  typedef struct {int p; logic w; logic [31:0] a, d; logic [3:0] b; int lat;} lbr_row_t;
  logic             clk = 1'b0;
  logic             rstn, brst, ece, eue, men;
  logic [1:0]       vld, rds, wrs, rdy, wt, ce, ue;
  logic [1:0][31:0] adr, wd, rdat;
  logic [1:0][3:0]  be;
  logic [4:0]       mwe;
  logic [8:0]       madr;
  logic [39:0]      mwd, mrd, flip;
  logic [31:0]      rd;
  logic [3:0]       err;
  logic [1:0]       epl;
  int               n;
  int               errors = 0;
  int               total_checks = 0;
  lbr_row_t rows[10] = '{'{0, 1, 32'h0, 32'h11223344, 4'hF, 0},
    '{1, 0, 32'h0, 32'h11223344, 4'hF, 0}, '{0, 1, 32'h0, 32'h000000AA, 4'h1, 2},
    '{1, 1, 32'h1, 32'h0000BB00, 4'h2, 2}, '{0, 1, 32'h2, 32'hCCDD0000, 4'hC, 2},
    '{0, 0, 32'h0, 32'hCCDDBBAA, 4'hF, 0}, '{1, 1, 32'h7FC, 32'hA5A5F00F, 4'hF, 0},
    '{0, 1, 32'h7FF, 32'h5A000000, 4'h8, 2}, '{0, 0, 32'h7FC, 32'h5AA5F00F, 4'hF, 0},
    '{1, 0, 32'h800, 32'hCCDDBBAA, 4'hF, 0}};
  logic [39:0] flips[4] = '{40'h1, 40'h80000000, 40'h0800000000, 40'h3};
  logic [3:0]  errs[4] = '{4'h1, 4'h2, 4'h1, 4'h8};
  lbr_ctrl #(.NUM_PORTS(2), .MEM_BYTES(2048), .ECC_ON(1'b1)) u_lbr_ctrl (.clk(clk),
    .rstn(rstn), .bus_reset_in(brst), .bus_addr_valid(vld), .bus_read_strobe(rds),
    .bus_write_strobe(wrs), .bus_addr(adr), .bus_wdata(wd), .bus_lane_enables(be),
    .port_rdata(rdat), .port_ready(rdy), .port_wait(wt), .port_correctable_err(ce),
    .port_uncorrectable_err(ue), .ecc_correctable_pulse(ece),
    .ecc_uncorrectable_pulse(eue), .mem_en(men), .mem_we(mwe), .mem_addr(madr),
    .mem_wdata(mwd), .mem_rdata(mrd));
  lbr_ram_model #(.AW(9)) u_lbr_ram_model (.clk(clk), .mem_en(men), .mem_we(mwe),
    .mem_addr(madr), .mem_wdata(mwd), .flip(flip), .mem_rdata(mrd));
  always #5 clk = ~clk;
  task automatic check(input string what, input logic [39:0] seen, input logic [39:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic complete_run;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : complete_run
  // One strobe; address and data stay put until the next access.
  task automatic op(input int p, input logic w, input logic [31:0] a, d, input logic [3:0] b);
    @(negedge clk);
    {vld[p], wrs[p], rds[p]} = {1'b1, w, !w};
    {adr[p], wd[p], be[p]} = {a, d, b};
    @(negedge clk);
    vld[p] = 1'b0;
    n = 0;
    while (rdy[p] !== 1'b1 && n < 8) begin
      @(negedge clk);
      n++;
    end
    rd = rdat[p];
    err = {ue, ce};
    epl = {eue, ece};
  endtask : op
  // ----------------------------------------------------------------------
  // Stimulus.
  // ----------------------------------------------------------------------
  initial begin
    {rstn, brst, vld, rds, wrs, adr, wd, be, flip} = '0;
    repeat (3) @(negedge clk);
    check("reset outputs", {rdy, wt, men, mwe, ece, eue}, 40'h0);
    rstn = 1'b1;
    foreach (rows[i]) begin
      op(rows[i].p, rows[i].w, rows[i].a, rows[i].d, rows[i].b);
      check("latency", n, rows[i].lat);
      if (!rows[i].w) check("read data", rd, rows[i].d);
      check("error flags", {epl, err}, 6'h00);
    end
    foreach (flips[i]) begin
      @(negedge clk);
      flip = flips[i];
      op(i % 2, 1'b0, 32'h0, 32'h0, 4'hF);
      flip = '0;
      check("flagged error", err, errs[i]);
      check("corrected latency", n, 0);
      check("error pulse", epl, {|errs[i][3:2], |errs[i][1:0]});
      if (i < 3) check("corrected data", rd, 32'hCCDDBBAA);
    end
    @(negedge clk);
    {adr[0], adr[1], vld, wrs, rds} = {32'h0, 32'h7FC, 6'h33};
    @(negedge clk);
    vld = 2'b00;
    check("first grant", {rdy, wt, rdat[0]}, {4'h6, 32'hCCDDBBAA});
    @(negedge clk);
    check("held grant", {rdy, wt, rdat[1]}, {4'h8, 32'h5AA5F00F});
    {adr[0], vld} = {32'h7FC, 2'b01};
    @(negedge clk);
    adr[0] = 32'h0;
    check("first of pair", {rdy, rdat[0]}, {2'b01, 32'h5AA5F00F});
    @(negedge clk);
    vld = 2'b11;
    check("second of pair", {rdy, rdat[0]}, {2'b01, 32'hCCDDBBAA});
    @(negedge clk);
    {vld, brst} = 3'b001;
    @(negedge clk);
    brst = 1'b0;
    check("bus reset clears", {rdy, wt, men}, 5'h00);
    @(negedge clk);
    check("held request dropped", {rdy, wt, men}, 5'h00);
    complete_run();
  end
  initial begin
    #20000;
    errors++;
    complete_run();
  end
endmodule : lbr_ctrl_tb
